// >>> inc/cdcc_pkg.sv
// Shared constants, register layout and carrier types of the converter control block.
// Assumes a byte-wide register port fed by the serial interface and a 25 MHz core clock.
package cdcc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [7:0] CFG_OFFSET = 8'h0f;
	localparam logic [7:0] TIMER_OFFSET = 8'h10;
	localparam logic [7:0] TRIM1_OFFSET = 8'h11;
	localparam logic [7:0] TRIM2_OFFSET = 8'h12;
	localparam logic [7:0] SERIAL0_OFFSET = 8'h13;
	localparam logic [7:0] SERIAL1_OFFSET = 8'h14;
	localparam logic [7:0] SERIAL2_OFFSET = 8'h15;
	localparam logic [7:0] SERIAL3_OFFSET = 8'h16;
	localparam logic [7:0] PART_IDENTIFICATION_OFFSET = 8'h17;

	////////////////////////////////////////////////////////////////////////////
	// Converter mode codes; codes with the top bit set are not to be written
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_CONT = 3'h1;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_PWRDN = 3'h3;

	////////////////////////////////////////////////////////////////////////////
	// Field layouts, msb first as they sit in the byte
	typedef struct packed {
		logic fixed_threshold_select;
		logic [1:0] cmp_mode;
		logic en_ch1;
		logic en_ch2;
		logic [2:0] converter_mode;
	} cdcc_cfg_t;

	typedef struct packed {
		logic offset_trim_enable;
		logic auto_trim_tracking;
		logic [5:0] offset_trim_code;
	} cdcc_trim_t;

	// One register access from the serial side; wr and rd are one-cycle strobes
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cdcc_reg_req_t;

	// Running data average of one channel, valid for one cycle
	localparam int DATA_W = 16;
	typedef struct packed {
		logic avg_valid;
		logic [DATA_W-1:0] avg;
	} cdcc_meas_t;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam cdcc_cfg_t CFG_RESET = 8'h19;
	localparam logic [7:0] TIMER_RESET = 8'h00;
	localparam cdcc_trim_t TRIM_RESET = 8'hc0;
	localparam logic [31:0] SERIAL_DEFAULT = 32'h1234_5678; // Arbitrary value
	localparam logic [7:0] PART_IDENTIFICATION_DEFAULT = 8'h5a; // Arbitrary value

	////////////////////////////////////////////////////////////////////////////
	// Trim tracking window and step sizes per input range
	localparam logic [DATA_W-1:0] AVG_HIGH = 16'hc000; // Three quarters of full range
	localparam logic [DATA_W-1:0] AVG_LOW = 16'h4000; // One quarter of full range
	localparam logic [5:0] TRIM_STEP_RANGE0 = 6'h01;
	localparam logic [5:0] TRIM_STEP_RANGE1 = 6'h02;
	localparam logic [5:0] TRIM_STEP_RANGE2 = 6'h04;
	localparam logic [5:0] TRIM_STEP_RANGE3 = 6'h08;

	////////////////////////////////////////////////////////////////////////////
	// Power-down timeout step: four hours of core clock
	localparam longint unsigned CLK_HZ = 25_000_000;
	localparam longint unsigned SEC_PER_HOUR = 3600;
	localparam longint unsigned PD_STEP_HOURS = 4;
	localparam int PD_PRESCALE_W = 40;
	localparam logic [63:0] PD_STEP_CYCLES = 64'(PD_STEP_HOURS * SEC_PER_HOUR * CLK_HZ);

	// Step size of one automatic trim move for the selected range
	function automatic logic [5:0] trim_step(input logic [1:0] range_sel);
		case (range_sel)
			2'h0: return TRIM_STEP_RANGE0;
			2'h1: return TRIM_STEP_RANGE1;
			2'h2: return TRIM_STEP_RANGE2;
			default: return TRIM_STEP_RANGE3;
		endcase
	endfunction : trim_step

endpackage : cdcc_pkg

// >>> logic/cdcc_control.sv
// Converter control: mode sequencing, auto power-down timer, offset trim and id registers.
// Assumes a byte register port from the serial interface, synchronous analog status inputs.
`timescale 1ns/100ps
module cdcc_control import cdcc_pkg::*; #(
	parameter logic [PD_PRESCALE_W-1:0] STEP_CYCLES = PD_STEP_CYCLES[PD_PRESCALE_W-1:0],
	parameter logic [31:0] SERIAL_NUMBER = SERIAL_DEFAULT,
	parameter logic [7:0] PART_IDENTIFICATION = PART_IDENTIFICATION_DEFAULT
) (
	input logic ref_clk_in,
	input logic rst_b_in,
	input cdcc_reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	input logic [1:0] range_sel_in,
	input cdcc_meas_t [1:0] meas_in,
	input logic [1:0] cmp_active_in,
	input logic conv_done_in,
	output logic conv_start_out,
	output logic conv_chan_out,
	output logic analog_power_on_out,
	output logic fixed_threshold_out,
	output logic [1:0] cmp_mode_out,
	output cdcc_trim_t trim_ch1_out,
	output cdcc_trim_t trim_ch2_out
);

	typedef enum logic {CONV_READY, CONV_BUSY} cdcc_conv_state_t;

	cdcc_cfg_t cfg;
	logic [7:0] pd_timer;
	cdcc_trim_t [1:0] trim;
	cdcc_conv_state_t state;
	logic last_chan;
	logic [1:0] single_todo;
	logic [1:0] en_mask;
	logic [1:0] run_mask;
	logic mode_runs;
	logic single_finish;
	logic cfg_wr;
	logic [PD_PRESCALE_W-1:0] prescale;
	logic [5:0] step_cnt;
	logic [5:0] timer_value;
	logic prescale_wrap;
	logic pd_restart;
	logic pd_fire;
	logic [7:0] next_rdata;

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Write strobe aimed at one byte address
	function automatic logic wr_hit(input cdcc_reg_req_t req, input logic [7:0] addr);
		return req.wr && (req.addr == addr);
	endfunction : wr_hit

	// Next channel: alternate when both are wanted, else the only one
	function automatic logic pick_chan(input logic [1:0] mask, input logic last);
		if (mask == 2'b11) begin
			return ~last;
		end
		return mask[1];
	endfunction : pick_chan

	assign cfg_wr = wr_hit(reg_req_in, CFG_OFFSET);
	assign en_mask = {cfg.en_ch2, cfg.en_ch1};
	assign mode_runs = (cfg.converter_mode == MODE_CONT) || (cfg.converter_mode == MODE_SINGLE);

	////////////////////////////////////////////////////////////////////////////
	// Configuration register; the block itself moves the mode field too.
	// A host write wins over both internal mode changes, and the timeout wins over single-mode completion.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg <= CFG_RESET;
		end else if (cfg_wr) begin
			cfg <= cdcc_cfg_t'(reg_req_in.wdata);
		end else if (pd_fire) begin
			cfg.converter_mode <= MODE_PWRDN;
		end else if (single_finish) begin
			cfg.converter_mode <= MODE_IDLE;
		end
	end

	// Comparator setup passes straight on to the comparator logic
	assign fixed_threshold_out = cfg.fixed_threshold_select;
	assign cmp_mode_out = cfg.cmp_mode;

	// Everything analog is off in power-down; the register port keeps working
	assign analog_power_on_out = (cfg.converter_mode != MODE_PWRDN);

	////////////////////////////////////////////////////////////////////////////
	// Single conversion bookkeeping: one bit per channel still owed
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			single_todo <= 2'b00;
		end else if (cfg_wr) begin
			single_todo <= (reg_req_in.wdata[2:0] == MODE_SINGLE) ? {reg_req_in.wdata[3], reg_req_in.wdata[4]} : 2'b00;
		end else if (conv_done_in && (state == CONV_BUSY) && (cfg.converter_mode == MODE_SINGLE)) begin
			single_todo[conv_chan_out] <= 1'b0;
		end
	end

	// Channels that may be started now; idle and power-down start nothing
	always_comb begin
		case (cfg.converter_mode)
			MODE_CONT: run_mask = en_mask;
			MODE_SINGLE: run_mask = single_todo;
			default: run_mask = 2'b00;
		endcase
	end

	assign single_finish = (state == CONV_READY) && (cfg.converter_mode == MODE_SINGLE) && (single_todo == 2'b00);

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer: one start pulse, then wait for the digitizer
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= CONV_READY;
			conv_start_out <= 1'b0;
			conv_chan_out <= 1'b0;
			last_chan <= 1'b1;
		end else begin
			conv_start_out <= 1'b0;
			case (state)
				CONV_READY: begin
					if (run_mask != 2'b00) begin
						conv_start_out <= 1'b1;
						conv_chan_out <= pick_chan(run_mask, last_chan);
						state <= CONV_BUSY;
					end
				end
				CONV_BUSY: begin
					// Leaving the running modes abandons the conversion in flight
					if (!mode_runs) begin
						state <= CONV_READY;
					end else if (conv_done_in) begin
						last_chan <= conv_chan_out;
						state <= CONV_READY;
					end
				end
				default: begin
					state <= CONV_READY;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-down timer register; only the low six bits take part
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pd_timer <= TIMER_RESET;
		end else if (wr_hit(reg_req_in, TIMER_OFFSET)) begin
			pd_timer <= reg_req_in.wdata;
		end
	end

	assign timer_value = pd_timer[5:0];

	// Counting stops while already powered down, so nothing fires twice
	assign pd_restart = (cmp_active_in != 2'b00) || wr_hit(reg_req_in, TIMER_OFFSET)
		|| (timer_value == 6'h00) || (cfg.converter_mode == MODE_PWRDN);
	assign prescale_wrap = (prescale == STEP_CYCLES - 1'b1);
	assign pd_fire = !pd_restart && prescale_wrap && (step_cnt == 6'(timer_value - 6'h01));

	// Cycle prescaler: one wrap per four-hour step
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prescale <= '0;
		end else if (pd_restart || prescale_wrap) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 1'b1;
		end
	end

	// Step counter compared against the programmed timeout
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			step_cnt <= 6'h00;
		end else if (pd_restart || pd_fire) begin
			step_cnt <= 6'h00;
		end else if (prescale_wrap) begin
			step_cnt <= step_cnt + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-channel offset trim, tracking only in adaptive threshold mode
	for (genvar g = 0; g < 2; g++) begin : g_trim
		cdcc_trim_track u_trim (
			.ref_clk_in(ref_clk_in),
			.rst_b_in(rst_b_in),
			.host_wr_in(wr_hit(reg_req_in, (g == 0) ? TRIM1_OFFSET : TRIM2_OFFSET)),
			.host_wdata_in(cdcc_trim_t'(reg_req_in.wdata)),
			.adaptive_in(!cfg.fixed_threshold_select),
			.range_sel_in(range_sel_in),
			.meas_in(meas_in[g]),
			.trim_out(trim[g])
		);
	end

	assign trim_ch1_out = trim[0];
	assign trim_ch2_out = trim[1];

	////////////////////////////////////////////////////////////////////////////
	// Read path; unmapped addresses read zero, serial number msb byte first
	always_comb begin
		case (reg_req_in.addr)
			CFG_OFFSET: next_rdata = cfg;
			TIMER_OFFSET: next_rdata = pd_timer;
			TRIM1_OFFSET: next_rdata = trim[0];
			TRIM2_OFFSET: next_rdata = trim[1];
			SERIAL0_OFFSET: next_rdata = SERIAL_NUMBER[31:24];
			SERIAL1_OFFSET: next_rdata = SERIAL_NUMBER[23:16];
			SERIAL2_OFFSET: next_rdata = SERIAL_NUMBER[15:8];
			SERIAL3_OFFSET: next_rdata = SERIAL_NUMBER[7:0];
			PART_IDENTIFICATION_OFFSET: next_rdata = PART_IDENTIFICATION;
			default: next_rdata = 8'h00;
		endcase
	end

	// Data held until the next read strobe
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_req_in.rd) begin
			reg_rdata_out <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	AST_IDLE_NO_START: assert property (conv_start_out
		|-> ($past(cfg.converter_mode) == MODE_CONT) || ($past(cfg.converter_mode) == MODE_SINGLE))
		else $error("conversion started outside a running mode");
	AST_ALTERNATE: assert property (conv_start_out && ($past(cfg.converter_mode) == MODE_CONT)
		&& ($past(en_mask) == 2'b11) |-> conv_chan_out != $past(last_chan))
		else $error("continuous mode did not alternate channels");
	AST_SINGLE_IDLE: assert property (single_finish && !cfg_wr && !pd_fire
		|=> cfg.converter_mode == MODE_IDLE)
		else $error("single mode did not return to idle");
	AST_PD_READ: assert property ((cfg.converter_mode == MODE_PWRDN) && reg_req_in.rd
		&& (reg_req_in.addr == PART_IDENTIFICATION_OFFSET) |=> reg_rdata_out == PART_IDENTIFICATION)
		else $error("register read failed in power-down");
	AST_PD_ENTER: assert property (pd_fire && !cfg_wr |=> cfg.converter_mode == MODE_PWRDN ##1 !conv_start_out)
		else $error("timeout did not power down");
	AST_TIMER_ZERO: assert property ((timer_value == 6'h00) |-> !pd_fire)
		else $error("auto power-down fired with timer disabled");
	AST_PD_STAYS: assert property ((cfg.converter_mode == MODE_PWRDN) && !cfg_wr
		|=> cfg.converter_mode == MODE_PWRDN)
		else $error("power-down left without host write");
	AST_TIMER_RESTART: assert property ((cmp_active_in != 2'b00) |=> (prescale == '0) && (step_cnt == 6'h00))
		else $error("comparator activity did not restart timer");
	AST_TRIM_READBACK: assert property (wr_hit(reg_req_in, TRIM1_OFFSET)
		|=> trim_ch1_out == $past(reg_req_in.wdata))
		else $error("trim write not stored");
	AST_SERIAL_READ: assert property (reg_req_in.rd && (reg_req_in.addr == SERIAL0_OFFSET)
		|=> reg_rdata_out == SERIAL_NUMBER[31:24])
		else $error("serial number byte wrong");
	AST_STEP_COUNT: assert property (pd_fire |-> step_cnt == 6'(timer_value - 6'h01))
		else $error("timeout fired at wrong step");

	COV_SINGLE_DONE: cover property (single_finish && !cfg_wr);
	COV_AUTO_PD: cover property (pd_fire);
	COV_ALTERNATE: cover property (conv_start_out && !conv_chan_out ##[1:40] conv_start_out && conv_chan_out);
	COV_PD_EXIT: cover property ((cfg.converter_mode == MODE_PWRDN) ##1 (cfg.converter_mode == MODE_CONT));

endmodule : cdcc_control

// >>> logic/cdcc_trim_track.sv
// One channel's offset trim register with automatic tracking of the data average.
// Assumes the average arrives with a one-cycle valid strobe from the digitizer.
`timescale 1ns/100ps
module cdcc_trim_track import cdcc_pkg::*; (
	input logic ref_clk_in,
	input logic rst_b_in,
	input logic host_wr_in,
	input cdcc_trim_t host_wdata_in,
	input logic adaptive_in,
	input logic [1:0] range_sel_in,
	input cdcc_meas_t meas_in,
	output cdcc_trim_t trim_out
);

	logic [5:0] step;
	logic track;
	logic go_up;
	logic go_down;
	logic [6:0] sum;
	logic [5:0] next_up_code;
	logic [5:0] next_down_code;

	////////////////////////////////////////////////////////////////////////////
	// Move decision; tracking is off in fixed threshold mode
	assign step = trim_step(range_sel_in);
	assign track = trim_out.auto_trim_tracking && adaptive_in && meas_in.avg_valid;
	assign go_up = track && (meas_in.avg > AVG_HIGH);
	assign go_down = track && (meas_in.avg < AVG_LOW);

	// Saturate rather than wrap, a wrap would swing the offset end to end
	assign sum = {1'b0, trim_out.offset_trim_code} + {1'b0, step};
	assign next_up_code = sum[6] ? 6'h3f : sum[5:0];
	assign next_down_code = (trim_out.offset_trim_code < step) ? 6'h00 : 6'(trim_out.offset_trim_code - step);

	// Host write overrides an automatic move in the same cycle
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			trim_out <= TRIM_RESET;
		end else if (host_wr_in) begin
			trim_out <= host_wdata_in;
		end else if (go_up) begin
			trim_out.offset_trim_code <= next_up_code;
		end else if (go_down) begin
			trim_out.offset_trim_code <= next_down_code;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	AST_TRIM_FIXED_HOLD: assert property (!adaptive_in && !host_wr_in |=> $stable(trim_out))
		else $error("trim moved in fixed threshold mode");
	AST_TRIM_UP: assert property (go_up && !host_wr_in && !sum[6]
		|=> trim_out.offset_trim_code == $past(trim_out.offset_trim_code) + $past(step))
		else $error("trim did not rise by one step");
	AST_TRIM_DOWN: assert property (go_down && !host_wr_in && (trim_out.offset_trim_code >= step)
		|=> trim_out.offset_trim_code == $past(trim_out.offset_trim_code) - $past(step))
		else $error("trim did not fall by one step");
	COV_TRIM_UP: cover property (go_up && !host_wr_in);

endmodule : cdcc_trim_track

// >>> sim/capacitance_converter_control_tb.sv
// Self-checking bench of the converter control block with host and digitizer models.
// Assumes a shortened timeout step of four cycles per timer count.
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module capacitance_converter_control_tb import cdcc_pkg::*;;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	cdcc_reg_req_t req;
	logic [7:0] rdata;
	logic [7:0] q;
	logic [1:0] range_sel = 2'h0;
	cdcc_meas_t [1:0] meas = '0;
	logic [1:0] cmp_act = 2'h0;
	logic done = 1'b0;
	logic start;
	logic chan;
	logic pwr_on;
	logic fixed_thr;
	logic [1:0] cmp_mode;
	cdcc_trim_t trim1;
	cdcc_trim_t trim2;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int dly = 0;
	int chans[$];
	logic [15:0] lfsr = 16'hf2c1;

	////////////////////////////////////////////////////////////////////////////
	// Design and host
	cdcc_control #(.STEP_CYCLES(40'h4)) u_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.reg_req_in(req), .reg_rdata_out(rdata), .range_sel_in(range_sel), .meas_in(meas),
		.cmp_active_in(cmp_act), .conv_done_in(done), .conv_start_out(start), .conv_chan_out(chan),
		.analog_power_on_out(pwr_on), .fixed_threshold_out(fixed_thr), .cmp_mode_out(cmp_mode),
		.trim_ch1_out(trim1), .trim_ch2_out(trim2));
	cdcc_host_model u_host (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .req_out(req));

	// Clock of 40 ns
	initial begin
		forever #20 ref_clk_in = ~ref_clk_in;
	end

	// Digitizer stand-in: logs channels, answers each start three cycles on
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles > 5000) begin
			err_count++;
			$display("[ERR] %0t run too long", $time);
			give_verdict();
		end else begin
			#1;
			done = (dly == 1);
			if (dly > 0) dly--;
			if (start === 1'b1) begin
				chans.push_back(int'(chan));
				dly = 3;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_step

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		u_host.xfer(1'b0, a, 8'h00, q);
		`CHECK_EQ(q, e)
	endtask : rd_chk

	// One average strobe; trim has moved by the return
	task automatic pulse(input int c, input logic [15:0] v);
		meas[c] = '{avg_valid: 1'b1, avg: v};
		cyc(1);
		meas[c].avg_valid = 1'b0;
		cyc(1);
	endtask : pulse

	task automatic trim_chk(input int c, input int code);
		cdcc_trim_t t;
		t = (c == 0) ? trim1 : trim2;
		`CHECK_EQ(t.offset_trim_code, 6'(code))
	endtask : trim_chk

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////
	// Register map: reset values, read-only bytes, unmapped place
	task automatic test_regs();
		logic [7:0] d;
		`CHECK_EQ(trim1.offset_trim_enable, 1'b1)
		rd_chk(TIMER_OFFSET, 8'h00);
		rd_chk(TRIM2_OFFSET, TRIM_RESET);
		for (int i = 0; i < 4; i++) begin
			wr(SERIAL0_OFFSET + 8'(i), 8'ha5);
			rd_chk(SERIAL0_OFFSET + 8'(i), SERIAL_DEFAULT[31 - 8 * i -: 8]);
		end
		wr(PART_IDENTIFICATION_OFFSET, 8'h00);
		rd_chk(PART_IDENTIFICATION_OFFSET, PART_IDENTIFICATION_DEFAULT);
		rd_chk(8'h20, 8'h00);
		// Random bytes through both trim registers
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_step(lfsr);
			d = lfsr[7:0];
			wr(i[0] ? TRIM2_OFFSET : TRIM1_OFFSET, d);
			rd_chk(i[0] ? TRIM2_OFFSET : TRIM1_OFFSET, d);
			`CHECK_EQ(i[0] ? trim2 : trim1, d)
		end
		$display("test regs done");
	endtask : test_regs

	// Tracking steps per range, strict window, saturation, fixed mode freeze
	task automatic test_trim();
		int c;
		int step;
		for (int r = 0; r < 4; r++) begin
			c = r % 2;
			step = 1 << r;
			range_sel = 2'(r);
			wr(CFG_OFFSET, 8'h18);
			wr(c ? TRIM2_OFFSET : TRIM1_OFFSET, 8'h7c);
			lfsr = lfsr_step(lfsr);
			pulse(c, {2'b11, lfsr[13:0]} | 16'h0001);
			trim_chk(c, (60 + step > 63) ? 63 : 60 + step);
			pulse(c, AVG_HIGH);
			trim_chk(c, (60 + step > 63) ? 63 : 60 + step);
			wr(c ? TRIM2_OFFSET : TRIM1_OFFSET, 8'h42);
			pulse(c, {2'b00, lfsr[13:0]});
			trim_chk(c, (2 - step < 0) ? 0 : 2 - step);
			wr(CFG_OFFSET, {1'b1, 2'(r), 5'h18});
			`CHECK_EQ(cmp_mode, 2'(r))
			`CHECK_EQ(fixed_thr, 1'b1)
			pulse(c, 16'hffff);
			trim_chk(c, (2 - step < 0) ? 0 : 2 - step);
		end
		$display("test trim done");
	endtask : test_trim

	// Idle, single, continuous and power-down sequencing
	task automatic test_modes();
		wr(CFG_OFFSET, 8'h18);
		cyc(10);
		chans.delete();
		cyc(20);
		`CHECK_EQ(chans.size(), 0)
		`CHECK_EQ(pwr_on, 1'b1)
		wr(CFG_OFFSET, 8'h1a);
		cyc(30);
		`CHECK_EQ(chans.size(), 2)
		`CHECK_EQ(chans[0] + 2 * chans[1], 2)
		rd_chk(CFG_OFFSET, 8'h18);
		chans.delete();
		wr(CFG_OFFSET, 8'h19);
		cyc(40);
		`CHECK_EQ(chans.size() >= 6, 1'b1)
		for (int i = 1; i < chans.size(); i++) begin
			`CHECK_EQ(chans[i], 1 - chans[i - 1])
		end
		wr(CFG_OFFSET, 8'h1b);
		cyc(5);
		chans.delete();
		`CHECK_EQ(pwr_on, 1'b0)
		rd_chk(PART_IDENTIFICATION_OFFSET, PART_IDENTIFICATION_DEFAULT);
		cyc(10);
		`CHECK_EQ(chans.size(), 0)
		$display("test modes done");
	endtask : test_modes

	// Auto power-down after value times step of quiet, restarts, disable
	task automatic test_timer();
		wr(CFG_OFFSET, 8'h18);
		wr(TIMER_OFFSET, 8'h02);
		cyc(6);
		`CHECK_EQ(pwr_on, 1'b1)
		cyc(6);
		`CHECK_EQ(pwr_on, 1'b0)
		cyc(20);
		rd_chk(CFG_OFFSET, 8'h1b);
		wr(CFG_OFFSET, 8'h18);
		`CHECK_EQ(pwr_on, 1'b1)
		for (int i = 0; i < 6; i++) begin
			cyc(5);
			cmp_act = 2'(1 + i % 2);
			cyc(1);
			cmp_act = 2'h0;
		end
		`CHECK_EQ(pwr_on, 1'b1)
		wr(TIMER_OFFSET, 8'h00);
		cyc(40);
		`CHECK_EQ(pwr_on, 1'b1)
		$display("test timer done");
	endtask : test_timer

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk_in);
		#1;
		rst_b_in = 1'b1;
		test_regs();
		test_trim();
		test_modes();
		test_timer();
		give_verdict();
	end
endmodule : capacitance_converter_control_tb

// >>> sim/cdcc_host_model.sv
// Host side model: issues byte register writes and reads on the register port.
// Assumes the port takes a strobe at the rising edge of ref_clk_in, no stall.
`timescale 1ns/100ps
module cdcc_host_model import cdcc_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic [7:0] rdata_in,
	output cdcc_reg_req_t req_out
);
	////////////////////////////////////////////////////////////////////////////
	// Port idles with both strobes low
	initial req_out = '0;

	// One access: strobe held for one edge, read byte taken just after it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] wd;
		wd = d;
		if (w && a == CFG_OFFSET) begin
			wd[2] = 1'b0; // Reserved mode codes never sent
		end
		if (w && a == TIMER_OFFSET) begin
			wd[7:6] = 2'h0; // Timer top bits kept zero
		end
		@(posedge ref_clk_in);
		#1;
		req_out = '{wr: w, rd: !w, addr: a, wdata: wd};
		@(posedge ref_clk_in);
		#1;
		req_out = '0;
		q = rdata_in;
	endtask : xfer
endmodule : cdcc_host_model
